// *** src/hbhp_host_port.sv ***
// Host bus handshake port with its APB configuration registers.
`timescale 1ns/1ps
module hbhp_host_port #(
  parameter int ACCESS_CYCLES = hbhp_pkg::HBHP_ACCESS_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic host_strobe_n_in,
  input wire logic host_rd_wr_in,
  input wire logic polarity_sel_in,
  input wire logic transparent_buffered_sel_in,
  input wire logic single_ended_sel_in,
  input wire logic [hbhp_pkg::HBHP_ADDR_W-1:0] host_addr_in,
  input wire logic [hbhp_pkg::HBHP_DATA_W-1:0] host_data_in,
  output logic [hbhp_pkg::HBHP_DATA_W-1:0] host_data_out,
  output logic host_data_oe_out,
  output logic host_ready_n_out,
  output logic io_cycle_active_n_out,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);
  import hbhp_pkg::*;

  // Width of the access down-counter.
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(ACCESS_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // Pin synchronisers: first stage feeds only the second stage.
  logic strobe_n_m_r, strobe_n_s_r, strobe_n_d_r;
  logic rd_wr_m_r, rd_wr_s_r;
  logic pol_m_r, pol_s_r;
  logic [HBHP_ADDR_W-1:0] addr_m_r, addr_s_r;
  logic [HBHP_DATA_W-1:0] data_m_r, data_s_r;

  // Sequencer state and captured request.
  hbhp_state_type state_r;
  hbhp_req_type req_r;
  logic [CNT_W-1:0] cnt_r;
  logic cyc_zero_wait_r; // Mode frozen for the cycle in flight.
  logic cfg_zero_wait_r; // Software wait-mode setting.
  logic [15:0] cycle_count_r; // Completed host cycles.

  // Word store interface.
  logic store_we;
  logic [HBHP_DATA_W-1:0] store_rd_data;
  logic start;
  logic decoded_write;

  // Two-flop synchronisers plus one delay flop for strobe edge detection.
  // The transparent and single-ended selects are never sampled at all.
  // The single-ended select has no reader, so its level changes nothing.
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      strobe_n_m_r <= 1'b1;
      strobe_n_s_r <= 1'b1;
      strobe_n_d_r <= 1'b1;
      rd_wr_m_r <= 1'b0;
      rd_wr_s_r <= 1'b0;
      pol_m_r <= 1'b0;
      pol_s_r <= 1'b0;
      addr_m_r <= '0;
      addr_s_r <= '0;
      data_m_r <= '0;
      data_s_r <= '0;
    end
    else
    begin
      strobe_n_m_r <= host_strobe_n_in;
      strobe_n_s_r <= strobe_n_m_r;
      strobe_n_d_r <= strobe_n_s_r;
      rd_wr_m_r <= host_rd_wr_in;
      rd_wr_s_r <= rd_wr_m_r;
      pol_m_r <= polarity_sel_in;
      pol_s_r <= pol_m_r;
      addr_m_r <= host_addr_in;
      addr_s_r <= addr_m_r;
      data_m_r <= host_data_in;
      data_s_r <= data_m_r;
    end
  end

  // A cycle starts on a falling strobe seen while idle.
  assign start = (state_r == HBHP_IDLE) && !strobe_n_s_r && strobe_n_d_r;

  // Polarity high: line high reads; polarity low: line high writes.
  assign decoded_write = (pol_s_r == HBHP_POL_HIGH_READ) ? !rd_wr_s_r
                                                         : rd_wr_s_r;

  // Write the word in the first access cycle, one cycle before a nonzero-wait ready falls.
  assign store_we = (state_r == HBHP_ACCESS) && req_r.write &&
                    (cnt_r == CNT_LOAD);

  // Handshake sequencer: capture, internal access, then hold for release.
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_r <= HBHP_IDLE;
      req_r <= '0;
      cnt_r <= '0;
      cyc_zero_wait_r <= HBHP_CFG_ZERO_WAIT_RST;
      host_ready_n_out <= 1'b1;
      io_cycle_active_n_out <= 1'b1;
      host_data_out <= '0;
      host_data_oe_out <= 1'b0;
      cycle_count_r <= '0;
    end
    else
    begin
      unique case (state_r)
        HBHP_IDLE:
        begin
          // Ready stays high here in either mode.
          if (start)
          begin
            req_r.write <= decoded_write;
            req_r.addr <= addr_s_r;
            req_r.data <= data_s_r;
            cnt_r <= CNT_LOAD;
            // The mode is latched once per cycle and never mid-cycle.
            cyc_zero_wait_r <= cfg_zero_wait_r;
            io_cycle_active_n_out <= 1'b0;
            // Zero-wait ready drops as soon as the transfer is seen.
            host_ready_n_out <= !cfg_zero_wait_r;
            state_r <= HBHP_ACCESS;
          end
        end
        HBHP_ACCESS:
        begin
          if (cnt_r == CNT_ZERO)
          begin
            io_cycle_active_n_out <= 1'b1;
            cycle_count_r <= cycle_count_r + 16'h0001;
            host_data_out <= store_rd_data;
            host_data_oe_out <= !req_r.write;
            // Zero-wait restores ready; nonzero-wait asserts it now that
            // read data is valid or the write is stored.
            host_ready_n_out <= cyc_zero_wait_r;
            state_r <= HBHP_HOLD;
          end
          else
          begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        HBHP_HOLD:
        begin
          // Host holds strobe until it sees ready low, so wait here.
          if (strobe_n_s_r)
          begin
            host_ready_n_out <= 1'b1;
            host_data_oe_out <= 1'b0;
            state_r <= HBHP_IDLE;
          end
        end
      endcase
    end
  end

  // The storage behind the port.
  hbhp_word_store #(
    .DATA_W(HBHP_DATA_W),
    .ADDR_W(HBHP_ADDR_W)
  ) u_store (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .wr_en_in(store_we),
    .addr_in(req_r.addr),
    .wr_data_in(req_r.data),
    .rd_data_out(store_rd_data)
  );

  // APB slave: pready rises in the second access cycle, one wait state.
  // Writes are taken at the edge that sees pready high; read data and pslverr are registered one edge earlier.
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= '0;
      cfg_zero_wait_r <= HBHP_CFG_ZERO_WAIT_RST;
    end
    else
    begin
      pready_out <= psel_in && penable_in && !pready_out;
      if (psel_in && penable_in && !pready_out)
      begin
        prdata_out <= '0;
        pslverr_out <= 1'b0;
        if (paddr_in == HBHP_OFS_STATUS)
        begin
          prdata_out[HBHP_ST_BUSY_BIT] <= (state_r == HBHP_ACCESS);
          prdata_out[HBHP_ST_READY_BIT] <= host_ready_n_out;
          prdata_out[HBHP_ST_MODE_BIT] <= cyc_zero_wait_r;
          prdata_out[HBHP_ST_COUNT_LSB +: 16] <= cycle_count_r;
        end
        else if (paddr_in == HBHP_OFS_CONFIG)
        begin
          prdata_out[HBHP_CFG_ZERO_WAIT_BIT] <= cfg_zero_wait_r;
        end
        else
        begin
          // Unmapped addresses read zero and flag an error.
          pslverr_out <= 1'b1;
        end
      end
      if (psel_in && penable_in && pready_out && pwrite_in &&
          paddr_in == HBHP_OFS_CONFIG)
      begin
        cfg_zero_wait_r <= pwdata_in[HBHP_CFG_ZERO_WAIT_BIT];
      end
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  // Ready is high whenever no cycle is being served.
  idle_ready_high_a: assert property (
    state_r == HBHP_IDLE |-> host_ready_n_out)
    else $error("Ready low while idle.");

  // Nonzero-wait read: ready falls together with valid driven data.
  read_data_valid_a: assert property (
    $fell(host_ready_n_out) && !cyc_zero_wait_r && !req_r.write |->
      host_data_oe_out && host_data_out == store_rd_data)
    else $error("Read ready without valid data.");

  // Nonzero-wait write: word stored before ready falls, then it falls.
  write_before_ready_a: assert property (
    store_we && !cyc_zero_wait_r |->
      host_ready_n_out ##1 host_ready_n_out ##[1:4] !host_ready_n_out)
    else $error("Write ready ordering broken.");

  // Nonzero-wait ready stays low until the strobe is released.
  hold_until_release_a: assert property (
    state_r == HBHP_HOLD && !cyc_zero_wait_r && !strobe_n_s_r |=>
      !host_ready_n_out)
    else $error("Ready released while strobe held.");

  // Zero-wait: ready low right after start and high again shortly.
  zero_wait_pulse_a: assert property (
    start && cfg_zero_wait_r |=> !host_ready_n_out ##[1:4] host_ready_n_out)
    else $error("Zero-wait ready pulse broken.");

  // Cycle-active is low exactly while the access is under way.
  io_active_span_a: assert property (
    start |=> !io_cycle_active_n_out [*2] ##[0:4]
      (io_cycle_active_n_out && state_r == HBHP_HOLD))
    else $error("Cycle-active span wrong.");

  // A read is a line level equal to the polarity select; else a write.
  polarity_sense_a: assert property (
    start |=> req_r.write == ($past(rd_wr_s_r) != $past(pol_s_r)))
    else $error("Read/write sense wrong.");

  // The frozen mode never changes while a cycle is in flight.
  mode_static_a: assert property (
    state_r != HBHP_IDLE |=> $stable(cyc_zero_wait_r))
    else $error("Wait mode changed mid-cycle.");

  // APB answer is a single-cycle pulse.
  apb_ready_pulse_a: assert property (
    pready_out |=> !pready_out)
    else $error("APB ready held too long.");

endmodule

// *** src/hbhp_pkg.sv ***
// Constants and carrier types for the host bus handshake port.
// Summary of operation
// - Transparent select tied low; buffered only.
// - Nonzero-wait read: ready low once data valid.
// - Nonzero-wait write: ready low after word stored.
// - Zero-wait mode: ready high while idle.
// - Zero-wait: ready low during transfer, then high.
// - Cycle-active output low during the internal access, high again in hold.
// - Single-ended select input is ignored entirely.
// - Polarity select sets read/write line sense.
package hbhp_pkg;

  // Host data bus width and address width of the word store.
  localparam int HBHP_DATA_W = 16;
  localparam int HBHP_ADDR_W = 4;

  // Internal access time of one host cycle, in clock cycles.
  localparam int HBHP_ACCESS_CYCLES = 2;

  // APB register byte offsets.
  localparam logic [11:0] HBHP_OFS_CONFIG = 12'h000;
  localparam logic [11:0] HBHP_OFS_STATUS = 12'h004;

  // Config register fields and reset value.
  localparam int HBHP_CFG_ZERO_WAIT_BIT = 0;
  localparam logic HBHP_CFG_ZERO_WAIT_RST = 1'b0;

  // Status register fields.
  localparam int HBHP_ST_BUSY_BIT = 0;
  localparam int HBHP_ST_READY_BIT = 1;
  localparam int HBHP_ST_MODE_BIT = 2;
  localparam int HBHP_ST_COUNT_LSB = 16;

  // Polarity select level meaning "line high is a read".
  localparam logic HBHP_POL_HIGH_READ = 1'b1;

  // One captured host request.
  typedef struct packed {
    logic write;
    logic [HBHP_ADDR_W-1:0] addr;
    logic [HBHP_DATA_W-1:0] data;
  } hbhp_req_type;

  // Handshake sequencer states.
  typedef enum logic [1:0] {
    HBHP_IDLE,
    HBHP_ACCESS,
    HBHP_HOLD
  } hbhp_state_type;

endpackage

// *** src/hbhp_word_store.sv ***
// Word store of flip-flops behind the host port.
`timescale 1ns/1ps
module hbhp_word_store #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 4
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic wr_en_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  output logic [DATA_W-1:0] rd_data_out
);

  // The storage array, one word per address.
  logic [DATA_W-1:0] mem_r [2**ADDR_W];

  // Write and registered read; a read of the word being written sees the
  // old value, which the sequencer avoids by reading after the write.
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rd_data_out <= '0;
      for (int i = 0; i < 2**ADDR_W; i++)
      begin
        mem_r[i] <= '0;
      end
    end
    else
    begin
      if (wr_en_in)
      begin
        mem_r[addr_in] <= wr_data_in;
      end
      rd_data_out <= mem_r[addr_in];
    end
  end

endmodule

// *** verification/hbhp_host_model.sv ***
// Host processor model driving strobe cycles into the handshake port.
`timescale 1ns/1ps
module hbhp_host_model (
  input wire logic clk_sys_in,
  input wire logic pol_in,
  input wire logic ready_n_in,
  input wire logic io_n_in,
  input wire logic [hbhp_pkg::HBHP_DATA_W-1:0] rd_in,
  output logic strobe_n_out,
  output logic rd_wr_out,
  output logic [hbhp_pkg::HBHP_ADDR_W-1:0] addr_out,
  output logic [hbhp_pkg::HBHP_DATA_W-1:0] wd_out
);
  import hbhp_pkg::*;

  // The bus idles with the strobe released.
  initial
  begin
    strobe_n_out = 1'b1;
    rd_wr_out = 1'b0;
    addr_out = '0;
    wd_out = '0;
  end

  // Waits on ready; the io line is only counted, never acted on.
  task automatic wait_ready(input logic lvl, inout int io_low,
    inout logic ok);
    int n;
    n = 0;
    while (ready_n_in !== lvl && n < 40)
    begin
      @(posedge clk_sys_in);
      io_low += (io_n_in === 1'b0);
      n++;
    end
    if (n >= 40) ok = 1'b0;
  endtask

  // One whole host cycle; ok falls if any wait runs out.
  task automatic cycle(input logic wr, input logic [HBHP_ADDR_W-1:0] a,
    input logic [HBHP_DATA_W-1:0] d, input logic zw,
    output logic [HBHP_DATA_W-1:0] q, output int io_low, output logic ok);
    ok = 1'b1;
    io_low = 0;
    @(posedge clk_sys_in);
    strobe_n_out <= 1'b0;
    rd_wr_out <= pol_in ^ wr;
    addr_out <= a;
    wd_out <= d;
    wait_ready(1'b0, io_low, ok);
    if (zw) wait_ready(1'b1, io_low, ok);
    q = rd_in;
    // Released lines show inverted values, so stale data cannot match.
    strobe_n_out <= 1'b1;
    addr_out <= ~a;
    wd_out <= ~d;
    wait_ready(1'b1, io_low, ok);
    repeat (4) @(posedge clk_sys_in);
  endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the host bus handshake port.
`timescale 1ns/1ps
module tb;
  import hbhp_pkg::*;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic pol = 1'b1;
  logic sngl = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic strobe_n;
  logic rd_wr;
  logic ready_n;
  logic io_n;
  logic oe;
  logic [HBHP_ADDR_W-1:0] haddr;
  logic [HBHP_DATA_W-1:0] hwd;
  logic [HBHP_DATA_W-1:0] hrd;
  logic [HBHP_DATA_W-1:0] hbus;
  int failures = 0;
  int cmp_count = 0;
  int ncyc = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  // An undriven data bus reads inverted, so a read without enable fails.
  assign hbus = oe ? hrd : ~hrd;

  // The buffered select stays grounded as the board must wire it.
  hbhp_host_port dut_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .host_strobe_n_in(strobe_n), .host_rd_wr_in(rd_wr),
    .polarity_sel_in(pol), .transparent_buffered_sel_in(1'b0),
    .single_ended_sel_in(sngl), .host_addr_in(haddr),
    .host_data_in(hwd), .host_data_out(hrd), .host_data_oe_out(oe),
    .host_ready_n_out(ready_n), .io_cycle_active_n_out(io_n),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr));

  hbhp_host_model host_u (.clk_sys_in(clk_sys_in), .pol_in(pol),
    .ready_n_in(ready_n), .io_n_in(io_n), .rd_in(hbus),
    .strobe_n_out(strobe_n), .rd_wr_out(rd_wr), .addr_out(haddr),
    .wd_out(hwd));

  // Prints the counts and the verdict, then stops the run.
  task automatic wrap_up();
    $display("failures %0d cmp_count %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; waits for pready under a bound.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    pen <= 1'b1;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // One host cycle; the ignored select toggles every time.
  task automatic host(input logic w, input logic [3:0] a,
    input logic [15:0] d, input logic zw, input logic [15:0] exp);
    logic [15:0] q;
    int io_low;
    logic ok;
    sngl <= ~sngl;
    host_u.cycle(w, a, d, zw, q, io_low, ok);
    ncyc++;
    if (ok !== 1'b1)
    begin
      failures++;
      wrap_up();
    end
    check("io active", 1'b1, io_low > 0);
    check("io idle", 1'b1, io_n);
    check("oe idle", 1'b0, oe);
    if (!w) check("host data", exp, q);
  endtask

  // Reset levels at the pins and in both registers.
  task automatic sc_reset();
    logic [31:0] q;
    logic e;
    check("ready idle", 1'b1, ready_n);
    check("io reset", 1'b1, io_n);
    apb(1'b0, HBHP_OFS_CONFIG, '0, q, e);
    check("config reset", 32'h0000_0000, q);
    check("config err", 1'b0, e);
    apb(1'b0, HBHP_OFS_STATUS, '0, q, e);
    check("status reset", 32'h0000_0002, q);
  endtask

  // Writes then reads four words under one read/write sense.
  task automatic sc_nonzero(input logic p);
    pol <= p;
    for (int i = 0; i < 4; i++)
      host(1'b1, 4'(i * 5), 16'h5a00 ^ {p, 15'(i)}, 1'b0, '0);
    for (int i = 0; i < 4; i++)
      host(1'b0, 4'(i * 5), '0, 1'b0, 16'h5a00 ^ {p, 15'(i)});
  endtask

  // Zero-wait cycles back to back, then a return to waited cycles.
  task automatic sc_zero();
    logic [31:0] q;
    logic e;
    apb(1'b1, HBHP_OFS_CONFIG, 32'h0000_0001, q, e);
    repeat (4) @(posedge clk_sys_in);
    check("zero idle ready", 1'b1, ready_n);
    host(1'b1, 4'h3, 16'hbeef, 1'b1, '0);
    host(1'b0, 4'h3, '0, 1'b1, 16'hbeef);
    host(1'b0, 4'h5, '0, 1'b1, 16'h5a01);
    apb(1'b0, HBHP_OFS_STATUS, '0, q, e);
    check("status mode", 1'b1, q[2]);
    check("status count", 32'(ncyc), {16'h0000, q[31:16]});
    apb(1'b1, HBHP_OFS_CONFIG, 32'hffff_fffe, q, e);
    host(1'b0, 4'h3, '0, 1'b0, 16'hbeef);
    apb(1'b0, HBHP_OFS_STATUS, '0, q, e);
    check("status mode", 1'b0, q[2]);
  endtask

  // Unmapped accesses are refused and leave the config alone.
  task automatic sc_refuse();
    logic [31:0] q;
    logic e;
    apb(1'b1, 12'h008, 32'hffff_ffff, q, e);
    check("unmapped write err", 1'b1, e);
    apb(1'b0, 12'h008, '0, q, e);
    check("unmapped read err", 1'b1, e);
    check("unmapped read data", 32'h0000_0000, q);
    apb(1'b0, HBHP_OFS_CONFIG, '0, q, e);
    check("config kept", 32'h0000_0000, q);
  endtask

  // Reset for eight cycles, then the scenarios in turn.
  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    sc_reset();
    sc_nonzero(1'b1);
    sc_nonzero(1'b0);
    sc_zero();
    sc_refuse();
    wrap_up();
  end
endmodule
